/* File: hw/irs_pkg.sv */
// constants, register map and state types of the infrared serial control block
`default_nettype none
package irs_pkg;
    // ************************************************
    // register map, byte offsets on the plain port
    // ************************************************
    localparam logic [2:0] OFS_CTL1   = 3'h0;
    localparam logic [2:0] OFS_CTL2   = 3'h1;
    localparam logic [2:0] OFS_CTL3   = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_DATA   = 3'h4;
    // control one fields; bit 5 is reserved and reads zero
    localparam int B_LOOP = 7, B_ENABLE = 6, B_NINE = 4, B_WAKE = 3;
    localparam int B_IDLE_STOP = 2, B_PAR_ON = 1, B_PAR_ODD = 0;
    localparam logic [7:0] CTL1_MASK = 8'hDF;
    // control two fields
    localparam int B_TXE_IE = 7, B_TXD_IE = 6, B_RXF_IE = 5, B_IDL_IE = 4;
    localparam int B_TX_EN = 3, B_RX_EN = 2, B_STANDBY = 1, B_BREAK = 0;
    // control three and status fields
    localparam int B_RX9 = 7, B_TX9 = 6, B_IR_SEL = 0;
    localparam int B_TXE_F = 7, B_TXD_F = 6, B_RXF_F = 5, B_IDL_F = 4, B_PAR_F = 3;
    localparam logic [7:0] RST_CTL = 8'h00;
    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int BAUD_HZ       = 115_200;
    localparam logic [10:0] BAUD_DIV = 11'(CLK_HZ / BAUD_HZ);
    localparam logic [10:0] HALF_BIT = 11'(CLK_HZ / BAUD_HZ / 2);
    localparam logic [10:0] IR_PULSE = 11'(CLK_HZ / BAUD_HZ * 3 / 16);
    // frame lengths in bits, start and stop included
    localparam logic [3:0] LEN8 = 4'hA;
    localparam logic [3:0] LEN9 = 4'hB;
    typedef enum logic {TX_IDLE, TX_SHIFT} irs_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} irs_rx_e;
endpackage
`default_nettype wire

/* File: hw/irs_uart.sv */
// serial transmitter and receiver with control registers and infrared output
`default_nettype none
module irs_uart (
    // clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_RST_B,
    // register port
    input  wire logic [2:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // serial pins, transmit is open drain
    input  wire logic       I_RXD,
    output logic            O_TXD_O,
    output logic            O_TXD_OE,
    // request lines
    output logic            O_TX_IRQ,
    output logic            O_RX_IRQ
);
    // ************************************************
    // registers and field aliases
    // ************************************************
    logic [7:0] ctl1_r, ctl2_r, tx_data_r, rx_data_r;
    logic       tx_ninth_r, rx_ninth_r, ir_sel_r;
    logic       tx_empty_r, tx_done_r, rx_full_r, idle_r, par_err_r;
    logic       en, nine, parity_on, podd, te, re, standby, send_break_ctl;
    logic [3:0] flen;
    assign en      = ctl1_r[irs_pkg::B_ENABLE];
    assign nine    = ctl1_r[irs_pkg::B_NINE];
    assign parity_on     = ctl1_r[irs_pkg::B_PAR_ON];
    assign podd    = ctl1_r[irs_pkg::B_PAR_ODD];
    assign te      = ctl2_r[irs_pkg::B_TX_EN];
    assign re      = ctl2_r[irs_pkg::B_RX_EN];
    assign standby = ctl2_r[irs_pkg::B_STANDBY];
    assign send_break_ctl     = ctl2_r[irs_pkg::B_BREAK];
    assign flen    = nine ? irs_pkg::LEN9 : irs_pkg::LEN8;

    // parity over the bits below the parity slot
    function automatic logic par_bit(input logic [8:0] d, input logic n9, input logic odd);
        par_bit = (n9 ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction

    logic wr1, wr2, wr3, wrd, rdd, wake_evt;
    assign wr1 = I_WR && I_ADDR == irs_pkg::OFS_CTL1;
    assign wr2 = I_WR && I_ADDR == irs_pkg::OFS_CTL2;
    assign wr3 = I_WR && I_ADDR == irs_pkg::OFS_CTL3;
    assign wrd = I_WR && I_ADDR == irs_pkg::OFS_DATA;
    assign rdd = I_RD && I_ADDR == irs_pkg::OFS_DATA;

    // control registers; enables ignore writes while the module is off
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctl1_r <= irs_pkg::RST_CTL;
            ctl2_r <= irs_pkg::RST_CTL;
        end else begin
            if (wr1) begin
                ctl1_r <= I_WDATA & irs_pkg::CTL1_MASK;
            end
            if (wr2) begin
                ctl2_r <= I_WDATA;
                if (!en) begin
                    ctl2_r[irs_pkg::B_TX_EN] <= te;
                    ctl2_r[irs_pkg::B_RX_EN] <= re;
                end
            end
            if (wake_evt) begin
                ctl2_r[irs_pkg::B_STANDBY] <= 1'b0;
            end
        end
    end

    // ninth bits and transmit data keep their value through reset
    always_ff @(posedge I_CLK) begin
        if (wr3) begin
            tx_ninth_r <= I_WDATA[irs_pkg::B_TX9];
        end
        if (wrd) begin
            tx_data_r <= I_WDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ir_sel_r <= 1'b0;
        end else if (wr3) begin
            ir_sel_r <= I_WDATA[irs_pkg::B_IR_SEL];
        end
    end

    // ************************************************
    // transmitter
    // ************************************************
    irs_pkg::irs_tx_e tx_st_r;
    logic [10:0] tx_cnt_r, tx_sh_r, ld_sh;
    logic [3:0]  tx_bits_r, ld_len;
    logic        te_prev_r, pend_r, brk_last_r, brk_req_r, tx_tick, tx_free, tx_busy, tx_line;
    logic        take_brk, take_tail, take_pre, take_dat, tx_par;
    logic [8:0]  tx_word;
    assign tx_tick = en && tx_cnt_r == irs_pkg::BAUD_DIV - 11'h001;
    assign tx_busy = tx_st_r == irs_pkg::TX_SHIFT;
    assign tx_free = tx_tick && (!tx_busy || tx_bits_r == 4'h1);
    assign tx_line = tx_busy ? tx_sh_r[0] : 1'b1;
    assign tx_word = {tx_ninth_r, tx_data_r};
    assign tx_par  = par_bit(tx_word, nine, podd);

    // what the next frame is: break, tail one, preamble, data, or nothing
    always_comb begin
        take_brk  = te && (send_break_ctl || brk_req_r);
        take_tail = !take_brk && brk_last_r;
        take_pre  = !take_brk && !take_tail && te && pend_r;
        take_dat  = !take_brk && !take_tail && !take_pre && te && !tx_empty_r;
        ld_sh     = {11{1'b1}};
        ld_len    = flen;
        if (take_brk) begin
            ld_sh = 11'h000;
        end else if (take_tail) begin
            ld_len = 4'h1;
        end else if (take_dat) begin
            ld_sh = {1'b1, tx_word, 1'b0};
            if (!nine) begin
                ld_sh[9] = 1'b1;
            end
            if (parity_on) begin
                ld_sh[nine ? 9 : 8] = tx_par;
            end
        end
    end

    // bit timer of the transmitter, held at zero while the module is off
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tx_cnt_r <= 11'h000;
        end else if (!en || tx_tick) begin
            tx_cnt_r <= 11'h000;
        end else begin
            tx_cnt_r <= tx_cnt_r + 11'h001;
        end
    end

    // shifter; a frame is only cut off by the module enable
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tx_st_r    <= irs_pkg::TX_IDLE;
            tx_sh_r    <= {11{1'b1}};
            tx_bits_r  <= 4'h0;
            brk_last_r <= 1'b0;
        end else if (!en) begin
            tx_st_r    <= irs_pkg::TX_IDLE;
            brk_last_r <= 1'b0;
        end else if (tx_free) begin
            brk_last_r <= take_brk;
            if (take_brk || take_tail || take_pre || take_dat) begin
                tx_st_r   <= irs_pkg::TX_SHIFT;
                tx_sh_r   <= ld_sh;
                tx_bits_r <= ld_len;
            end else begin
                tx_st_r <= irs_pkg::TX_IDLE;
            end
        end else if (tx_tick) begin
            tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
            case (tx_st_r)
                irs_pkg::TX_SHIFT: tx_st_r <= irs_pkg::TX_SHIFT;
                default:           tx_st_r <= irs_pkg::TX_IDLE;
            endcase
        end
    end

    // break request; a set-then-clear of the break bit between ticks is kept, not lost
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            brk_req_r <= 1'b0;
        end else begin
            if (!en || (tx_free && take_brk)) begin
                brk_req_r <= 1'b0;
            end
            if (en && wr2 && I_WDATA[irs_pkg::B_BREAK] && !send_break_ctl) begin
                brk_req_r <= 1'b1;
            end
        end
    end

    // preamble request; a fresh rising enable mid frame queues an idle frame
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            te_prev_r <= 1'b0;
            pend_r    <= 1'b0;
        end else begin
            te_prev_r <= te;
            if (!en || (tx_free && (take_pre || take_brk))) begin
                pend_r <= 1'b0;
            end
            if (te && !te_prev_r) begin
                pend_r <= 1'b1;
            end
        end
    end

    // empty and done flags; hardware set wins over the data write
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tx_empty_r <= 1'b1;
            tx_done_r  <= 1'b1;
        end else begin
            if (wrd) begin
                tx_empty_r <= 1'b0;
            end
            if (!en || (tx_free && take_dat)) begin
                tx_empty_r <= 1'b1;
            end
            tx_done_r <= !en || (tx_empty_r && !tx_busy && !pend_r && !take_brk);
        end
    end

    // pin drivers; infrared turns a zero bit into a short low pulse
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_TXD_O  <= 1'b1;
            O_TXD_OE <= 1'b0;
        end else begin
            O_TXD_O  <= tx_line || (ir_sel_r && tx_cnt_r >= irs_pkg::IR_PULSE);
            O_TXD_OE <= en && (te || tx_busy);
        end
    end

    // ************************************************
    // receiver
    // ************************************************
    irs_pkg::irs_rx_e rx_st_r;
    logic [10:0] rx_cnt_r;
    logic [9:0]  rx_sh_r;
    logic [3:0]  rx_bitn_r, ones_r;
    logic        rxd_s1_r, rxd_s2_r, rx_prev_r, rx_in, rx_on, samp, fall;
    logic        done, msb, accept, count_ctx, idle_evt, arm_r, wake;
    assign wake      = ctl1_r[irs_pkg::B_WAKE];
    assign rx_in     = ctl1_r[irs_pkg::B_LOOP] ? tx_line : rxd_s2_r;
    assign rx_on     = en && re;
    assign samp      = rx_on && rx_cnt_r == irs_pkg::HALF_BIT;
    assign fall      = rx_on && rx_st_r == irs_pkg::RX_IDLE && rx_prev_r && !rx_in;
    assign done      = samp && rx_st_r == irs_pkg::RX_BITS && rx_bitn_r == flen - 4'h2;
    assign msb       = nine ? rx_sh_r[8] : rx_sh_r[7];
    assign accept    = done && (!standby || (wake && msb));
    assign count_ctx = rx_st_r == irs_pkg::RX_IDLE
                    || (rx_st_r == irs_pkg::RX_BITS && !ctl1_r[irs_pkg::B_IDLE_STOP]);
    assign idle_evt  = samp && count_ctx && rx_in && ones_r == flen - 4'h1;
    assign wake_evt  = standby && (wake ? done && msb : idle_evt);

    // pin synchroniser, then the edge detector on the second stage
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rxd_s1_r  <= 1'b1;
            rxd_s2_r  <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rxd_s1_r  <= I_RXD;
            rxd_s2_r  <= rxd_s1_r;
            rx_prev_r <= rx_in;
        end
    end

    // bit timer realigned on each start edge, free running when idle
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rx_cnt_r <= 11'h000;
        end else if (!rx_on || fall || rx_cnt_r == irs_pkg::BAUD_DIV - 11'h001) begin
            rx_cnt_r <= 11'h000;
        end else begin
            rx_cnt_r <= rx_cnt_r + 11'h001;
        end
    end

    // frame sequencer; a high start sample is a glitch and is dropped
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rx_st_r   <= irs_pkg::RX_IDLE;
            rx_bitn_r <= 4'h0;
            rx_sh_r   <= 10'h000;
        end else if (!rx_on) begin
            rx_st_r <= irs_pkg::RX_IDLE;
        end else begin
            case (rx_st_r)
                irs_pkg::RX_IDLE: begin
                    if (fall) begin
                        rx_st_r <= irs_pkg::RX_START;
                    end
                end
                irs_pkg::RX_START: begin
                    if (samp) begin
                        rx_st_r   <= rx_in ? irs_pkg::RX_IDLE : irs_pkg::RX_BITS;
                        rx_bitn_r <= 4'h0;
                    end
                end
                irs_pkg::RX_BITS: begin
                    if (samp) begin
                        rx_sh_r[rx_bitn_r] <= rx_in;
                        rx_bitn_r          <= rx_bitn_r + 4'h1;
                        if (done) begin
                            rx_st_r <= irs_pkg::RX_IDLE;
                        end
                    end
                end
                default: rx_st_r <= irs_pkg::RX_IDLE;
            endcase
        end
    end

    // run of ones toward an idle character, saturating at one frame
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ones_r <= 4'h0;
        end else if (fall || (samp && !count_ctx)) begin
            ones_r <= 4'h0;
        end else if (samp) begin
            ones_r <= !rx_in ? 4'h0 : (ones_r == flen ? ones_r : ones_r + 4'h1);
        end
    end

    // received word and ninth bit, untouched by reset
    always_ff @(posedge I_CLK) begin
        if (accept) begin
            rx_data_r  <= rx_sh_r[7:0];
            rx_ninth_r <= msb;
        end
    end

    // receiver flags; a data read clears, a new event in that cycle wins
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rx_full_r <= 1'b0;
            idle_r    <= 1'b0;
            par_err_r <= 1'b0;
            arm_r     <= 1'b0;
        end else begin
            if (rdd) begin
                rx_full_r <= 1'b0;
                idle_r    <= 1'b0;
                par_err_r <= 1'b0;
            end
            if (accept) begin
                rx_full_r <= 1'b1;
                arm_r     <= 1'b1;
                if (parity_on && msb != par_bit(rx_sh_r[8:0], nine, podd)) begin
                    par_err_r <= 1'b1;
                end
            end
            if (idle_evt && !standby && arm_r) begin
                idle_r <= 1'b1;
                arm_r  <= 1'b0;
            end
        end
    end

    // ************************************************
    // requests and read port
    // ************************************************
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_TX_IRQ <= 1'b0;
            O_RX_IRQ <= 1'b0;
        end else begin
            O_TX_IRQ <= en && ((tx_empty_r && ctl2_r[irs_pkg::B_TXE_IE])
                            || (tx_done_r && ctl2_r[irs_pkg::B_TXD_IE]));
            O_RX_IRQ <= en && !standby && ((rx_full_r && ctl2_r[irs_pkg::B_RXF_IE])
                            || (idle_r && ctl2_r[irs_pkg::B_IDL_IE]));
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= 8'h00;
            if (I_RD) begin
                case (I_ADDR)
                    irs_pkg::OFS_CTL1:   O_RDATA <= ctl1_r;
                    irs_pkg::OFS_CTL2:   O_RDATA <= ctl2_r;
                    irs_pkg::OFS_CTL3:   O_RDATA <= {rx_ninth_r, tx_ninth_r, 5'h00, ir_sel_r};
                    irs_pkg::OFS_STATUS: O_RDATA <= {tx_empty_r, tx_done_r, rx_full_r,
                                                     idle_r, par_err_r, 3'h0};
                    irs_pkg::OFS_DATA:   O_RDATA <= rx_data_r;
                    default:             O_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    property p_off_flags;
        !en |=> tx_empty_r && tx_done_r && !O_TX_IRQ;
    endproperty
    a_off_flags: assert property (p_off_flags) else $error("module off left tx flags");

    property p_len;
        tx_free && take_dat |=> tx_bits_r == (nine ? irs_pkg::LEN9 : irs_pkg::LEN8);
    endproperty
    a_len: assert property (p_len) else $error("data frame length wrong");

    property p_parity;
        tx_free && take_dat && parity_on |=> tx_sh_r[nine ? 9 : 8] == $past(tx_par);
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit misplaced");

    property p_preamble;
        tx_free && take_pre |=> tx_sh_r == 11'h7FF && !pend_r;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble not all ones");

    property p_finish;
        tx_busy && en |-> ##1 O_TXD_OE;
    endproperty
    a_finish: assert property (p_finish) else $error("pin released mid frame");

    property p_break;
        tx_free && take_brk |=> tx_sh_r == 11'h000 && !pend_r && brk_last_r;
    endproperty
    a_break: assert property (p_break) else $error("break frame wrong");

    property p_rx_off;
        !rx_on && !rdd |=> $stable(rx_full_r) && $stable(idle_r);
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx flags moved while off");

    property p_standby;
        standby |=> !O_RX_IRQ;
    endproperty
    a_standby: assert property (p_standby) else $error("rx irq during standby");

    property p_ninth;
        accept |=> rx_ninth_r == $past(msb) && rx_full_r;
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit not captured");

    property p_empty;
        en && tx_free && take_dat |=> tx_empty_r;
    endproperty
    a_empty: assert property (p_empty) else $error("empty not set on load");

    property p_write;
        wr1 |=> ctl1_r == ($past(I_WDATA) & irs_pkg::CTL1_MASK);
    endproperty
    a_write: assert property (p_write) else $error("control write lost");

    c_preamble: cover property (tx_free && take_pre);
    c_break:    cover property (tx_free && take_brk);
    c_tail:     cover property (tx_free && take_tail);
    c_idle:     cover property (idle_evt && arm_r && !standby);
    c_wake:     cover property (wake_evt);
endmodule
`default_nettype wire

/* File: verification/irs_remote.sv */
// remote serial device: frame listener on the transmit pin, frame sender on the receive pin
`default_nettype none
module irs_remote #(
    parameter int BIT = 1736
) (
    // clock and pins
    input  wire logic       i_clk,
    input  wire logic       i_line,
    input  wire logic       i_listen,
    output logic            o_rxd,
    // captured character
    output logic            o_got,
    output logic      [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] sh;
    // ****************************************
    // listener: mid-bit samples, lsb first
    // ****************************************
    initial begin
        o_rxd = 1'b1;
        o_got = 1'b0;
        o_byte = 8'h00;
        sh = 9'h000;
        forever begin
            @(negedge i_line);
            // preamble has no start edge, so it is skipped for free
            if (i_listen) begin
                repeat (BIT / 2) @(posedge i_clk);
                repeat (9) begin
                    repeat (BIT) @(posedge i_clk);
                    sh = {i_line, sh[8:1]};
                end
                o_byte <= sh[7:0];
                o_got  <= 1'b1;
                @(posedge i_clk);
                o_got  <= 1'b0;
            end
        end
    end
    // sender: start, eight data lsb first, stop; idles high like the pull-up
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= f[i];
            repeat (BIT) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: verification/irs_uart_tb.sv */
// self-checking bench for the infrared serial control block
`default_nettype none
module irs_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string n; logic [7:0] v;} irs_exp_s;
    logic       clk, rst_b, wr, rd, rd_d, txd_o, txd_oe, tx_irq, rx_irq, rxd, got, listen;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rx_byte, d;
    wire        line = txd_oe ? txd_o : 1'b1; // pull-up on the open-drain pin
    irs_exp_s   exp_q[$];
    irs_exp_s   e;
    logic [7:0] txq[$];
    int         mismatches, checked, seed, n;
    irs_uart u_irs_uart (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RXD(rxd), .O_TXD_O(txd_o),
        .O_TXD_OE(txd_oe), .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq));
    irs_remote u_irs_remote (.i_clk(clk), .i_line(line), .i_listen(listen), .o_rxd(rxd),
        .o_got(got), .o_byte(rx_byte));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        checked++;
        if (g !== ex) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // one strobe per call, a free edge after it so no signal is set twice at once
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] v, input string nm);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        if (w) begin
            wr <= 1'b1;
        end else begin
            rd <= 1'b1;
            exp_q.push_back(irs_exp_s'{nm, v});
        end
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic hold(input int lim, input bit sel);
        for (n = 0; n < lim && (sel ? got : rx_irq) !== 1'b1; n++) @(posedge clk);
        if (n >= lim) begin
            mismatches++;
            $display("wrong value wait expected 1 seen 0");
            stop_test();
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watcher: every answer takes the oldest note
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            e = exp_q.pop_front();
            chk(e.n, e.v, rdata);
        end
        if (got) begin
            chk("frame", txq.pop_front(), rx_byte);
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0; addr = 3'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        listen = 1'b1; mismatches = 0; checked = 0; seed = 61160;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, irs_pkg::OFS_CTL1, 8'h00, "ctl1");
        bus(0, irs_pkg::OFS_CTL2, 8'h00, "ctl2");
        bus(0, irs_pkg::OFS_STATUS, 8'hC0, "status");
        bus(0, 3'h5, 8'h00, "unmapped");
        d = 8'($random(seed));
        bus(1, irs_pkg::OFS_CTL1, d, "");
        bus(0, irs_pkg::OFS_CTL1, d & irs_pkg::CTL1_MASK, "ctl1 rand");
        $display("test registers done");
        // odd parity in bit 7 of an eight-bit frame, after the preamble
        bus(1, irs_pkg::OFS_CTL1, 8'h43, "");
        #1 chk("oe off", 8'h00, {7'h00, txd_oe});
        bus(1, irs_pkg::OFS_CTL3, 8'h40, "");
        bus(1, irs_pkg::OFS_CTL2, 8'h88, "");
        repeat (2) @(posedge clk);
        #1 chk("oe on", 8'h01, {7'h00, txd_oe});
        chk("tx irq", 8'h01, {7'h00, tx_irq});
        d = 8'($random(seed));
        txq.push_back({~^d[6:0], d[6:0]});
        bus(1, irs_pkg::OFS_DATA, d, "");
        hold(40000, 1'b1);
        $display("test transmit done");
        // loopback still drives the transmit pin, so the listener is switched off
        listen = 1'b0;
        bus(1, irs_pkg::OFS_CTL1, 8'hC0, "");
        bus(1, irs_pkg::OFS_CTL2, 8'hAC, "");
        d = 8'($random(seed));
        bus(1, irs_pkg::OFS_DATA, d, "");
        hold(25000, 1'b0);
        bus(0, irs_pkg::OFS_DATA, d, "loop data");
        $display("test loopback done");
        bus(1, irs_pkg::OFS_CTL1, 8'h40, "");
        d = 8'($random(seed));
        u_irs_remote.send(d);
        hold(2000, 1'b0);
        bus(0, irs_pkg::OFS_DATA, d, "rx data");
        bus(0, irs_pkg::OFS_CTL3, {d[7], 7'h40}, "ninth bit");
        $display("test receive done");
        #1 chk("tx irq", 8'h01, {7'h00, tx_irq});
        bus(1, irs_pkg::OFS_CTL1, 8'h00, "");
        repeat (2) @(posedge clk);
        #1 chk("tx irq off", 8'h00, {7'h00, tx_irq});
        bus(0, irs_pkg::OFS_STATUS, 8'hC0, "status off");
        repeat (2) @(posedge clk);
        $display("test disable done");
        // mid-run reset: control bits clear, ninth bits survive
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, irs_pkg::OFS_CTL2, 8'h00, "ctl2 reset");
        bus(0, irs_pkg::OFS_CTL3, {d[7], 7'h40}, "ninth kept");
        bus(0, irs_pkg::OFS_STATUS, 8'hC0, "status reset");
        $display("test reset done");
        stop_test();
    end
endmodule
`default_nettype wire
